//--- omw_mode_ctrl.v
// operating mode, clock selection and wake-up controller
// ----------------------------------------------------------------------
// Functional notes
// - high_clock_select 0 with code 000/001 selects slow mode
// - sub clock selected stops fast clock and dividers
// - high_clock_select 1 or codes 010-111 give normal mode
// - halt with idle enable 0 enters sleep
// - idle enable 1, keep 0: clock-stopped idle
// - idle enable 1, keep 1: clock-running idle
// - memory, registers and ports retained in power-down
// - entering power-down clears watchdog, keeps counting
// - entering power-down sets pdf, clears timeout
// - wake on port A fall, interrupt, watchdog
// - watchdog wake sets timeout, resets pc/sp only
// - pdf cleared by power-up or clear-wdt, set by halt
// - per-pin port A wake mask, resume after halt
// - disabled or stack-full interrupt resumes after halt
// - enabled interrupt, stack free: normal interrupt response
// - flag already pending at entry cannot wake
// - fast clock wake 15-16 or 1-2 cycles
// - slow clock wake takes 1-2 cycles
// - high_clock_select 0 with codes 010-111 divides by 64 down to 2
// - fast ready low in sleep/idle_clock_stopped, rises 15-16 later
// ----------------------------------------------------------------------
`timescale 1ns/10ps
`include "omw_regs.vh"
module omw_mode_ctrl (
  // clock and reset
  input  wire                    clk_sys,
  input  wire                    arst_n,
  // oscillator ticks (one-cycle pulses at each oscillator edge)
  input  wire                    fast_osc_tick,
  input  wire                    slow_osc_tick,
  // mode control bits
  input  wire                    high_clock_select,
  input  wire [2:0]              sysclk_divider_select,
  input  wire                    idle_on_powerdown_enable,
  input  wire                    keep_sysclk_in_idle,
  // cpu instruction strobes
  input  wire                    halt_exec,
  input  wire                    clr_wdt_exec,
  // interrupt side
  input  wire [`OMW_IRQ_W-1:0]   irq_req,
  input  wire [`OMW_IRQ_W-1:0]   irq_enable,
  input  wire                    global_irq_enable,
  input  wire                    stack_full,
  // watchdog side
  input  wire                    wdt_overflow,
  // port A
  input  wire [`OMW_PORTA_W-1:0] port_a_in,
  input  wire [`OMW_PORTA_W-1:0] port_a_wake_mask,
  // clock outputs
  output reg                     high_speed_clock_en,
  output reg                     sysclk_tick,
  output reg                     sysclk_is_sub,
  output reg                     sub_clock_en,
  output reg                     time_base_en,
  // cpu control
  output reg                     cpu_halted,
  output reg                     hold_state,
  output reg                     wdt_clear,
  output reg                     pc_sp_reset,
  output reg                     irq_take,
  output reg                     resume_next,
  // status
  output reg  [1:0]              power_mode,
  output reg                     power_down_flag,
  output reg                     wdt_expiry_flag,
  output wire                    fast_osc_ready_flag,
  output wire                    slow_osc_ready_flag
);
  // ----------------------------------------------------------------------
  // clock selection
  // ----------------------------------------------------------------------
  wire sel_sub = ~high_clock_select &
                 ((sysclk_divider_select == `OMW_DIV_SUB0) |
                  (sysclk_divider_select == `OMW_DIV_SUB1));
  wire sel_fast = ~sel_sub;
  reg       mode_stops_fast;
  // ----------------------------------------------------------------------
  // system clock divider
  // ----------------------------------------------------------------------
  // a divided tick falls on the last count under the mask; the mask is not
  // registered, so a new ratio takes hold at once, even mid-period
  reg [5:0] div_cnt;
  reg [5:0] div_mask;
  always @* begin
    case (sysclk_divider_select)
      `OMW_DIV_64: div_mask = 6'h3F;
      `OMW_DIV_32: div_mask = 6'h1F;
      `OMW_DIV_16: div_mask = 6'h0F;
      `OMW_DIV_8:  div_mask = 6'h07;
      `OMW_DIV_4:  div_mask = 6'h03;
      `OMW_DIV_2:  div_mask = 6'h01;
      default:     div_mask = 6'h00;
    endcase
    // the undivided clock overrides the divider field
    if (high_clock_select)
      div_mask = 6'h00;
  end
  // fast source runs only when selected and not stopped by a power mode
  wire fast_on = sel_fast & ~mode_stops_fast;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      div_cnt <= 6'h00;
    else if (!fast_on)
      div_cnt <= 6'h00;
    else if (fast_osc_tick)
      div_cnt <= div_cnt + 6'h01;
  end
  wire div_hit = fast_osc_tick & ((div_cnt & div_mask) == div_mask);
  // ----------------------------------------------------------------------
  // power mode state
  // ----------------------------------------------------------------------
  reg [1:0]              next_mode;
  reg [`OMW_IRQ_W-1:0]   irq_blocked;
  reg [`OMW_PORTA_W-1:0] pa_fall;
  reg                    waking;
  reg [`OMW_CNT_W-1:0]   wake_cnt;
  reg                    wake_irq;
  reg                    wake_wdt;
  // every mode other than run counts as powered down
  wire in_pd = (power_mode != `OMW_MODE_RUN);
  always @* begin
    if (!idle_on_powerdown_enable)
      next_mode = `OMW_MODE_SLEEP;
    else if (!keep_sysclk_in_idle)
      next_mode = `OMW_MODE_IDLE_CLOCK_STOPPED;
    else
      next_mode = `OMW_MODE_IDLE_CLOCK_RUNNING;
  end
  // ----------------------------------------------------------------------
  // wake sources
  // ----------------------------------------------------------------------
  // a request pending at entry is masked off as a wake source
  wire [`OMW_IRQ_W-1:0] irq_fresh = irq_req & ~irq_blocked;
  wire irq_wake  = |irq_fresh;
  wire pa_wake   = |pa_fall;
  wire wake_evt  = in_pd & ~waking & (pa_wake | irq_wake | wdt_overflow);
  // ----------------------------------------------------------------------
  // wake timing
  // ----------------------------------------------------------------------
  // idle with its clock running skips the long fast settle
  wire [`OMW_CNT_W-1:0] wake_len =
    sysclk_is_sub ? `OMW_SLOW_SETTLE :
    (power_mode == `OMW_MODE_IDLE_CLOCK_RUNNING) ? `OMW_SHORT_SETTLE :
    `OMW_FAST_SETTLE;
  // a sub clock system times its wake in slow ticks
  wire wake_tick = sysclk_is_sub ? slow_osc_tick : fast_osc_tick;
  wire irq_serviceable = |(irq_fresh & irq_enable) &
                         global_irq_enable & ~stack_full;
  // one detector per pin; a masked pin never wakes the core
  genvar gi;
  generate
    for (gi = 0; gi < `OMW_PORTA_W; gi = gi + 1) begin : g_pa
      omw_edge_det u_edge (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .pin     (port_a_in[gi]),
        .enable  (port_a_wake_mask[gi] & in_pd),
        .fall    (pa_fall[gi])
      );
    end
  endgenerate
  // ----------------------------------------------------------------------
  // power mode register
  // ----------------------------------------------------------------------
  // a strobe is refused while powered down, and halt wins over a
  // clear-watchdog strobe in the same cycle
  wire halt_take = ~in_pd & halt_exec;
  wire clr_take  = ~in_pd & ~halt_exec & clr_wdt_exec;
  // the mode returns to run only once the wake count has run out
  wire wake_done = waking & wake_tick &
                   (wake_cnt == {`OMW_CNT_W{1'b0}});
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      power_mode  <= `OMW_MODE_RUN;
      irq_blocked <= {`OMW_IRQ_W{1'b0}};
    end else if (halt_take) begin
      power_mode  <= next_mode;
      irq_blocked <= irq_req;
    end else if (wake_done) begin
      power_mode  <= `OMW_MODE_RUN;
    end
  end
  // ----------------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      power_down_flag <= 1'b0;
      wdt_expiry_flag <= 1'b0;
    end else if (halt_take) begin
      power_down_flag <= 1'b1;
      wdt_expiry_flag <= 1'b0;
    end else begin
      if (clr_take)
        power_down_flag <= 1'b0;
      // a watchdog wake marks the timeout and touches no other flag
      if (wake_evt && wdt_overflow)
        wdt_expiry_flag <= 1'b1;
    end
  end
  // ----------------------------------------------------------------------
  // wake sequencer
  // ----------------------------------------------------------------------
  // the cause is latched at the wake event, so a watchdog source that goes away
  // during the count still decides; an interrupt is taken only if still pending
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      waking   <= 1'b0;
      wake_cnt <= `OMW_FAST_SETTLE;
      wake_irq <= 1'b0;
      wake_wdt <= 1'b0;
    end else if (wake_evt) begin
      waking   <= 1'b1;
      wake_cnt <= wake_len;
      wake_irq <= irq_wake & ~wdt_overflow;
      wake_wdt <= wdt_overflow;
    end else if (wake_done) begin
      waking   <= 1'b0;
    end else if (waking && wake_tick) begin
      wake_cnt <= wake_cnt - 1'b1;
    end
  end
  // ----------------------------------------------------------------------
  // watchdog clear and resume pulses
  // ----------------------------------------------------------------------
  // each wake ends in exactly one of the three resume pulses, and a
  // watchdog cause is taken before an interrupt
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wdt_clear   <= 1'b0;
      pc_sp_reset <= 1'b0;
      irq_take    <= 1'b0;
      resume_next <= 1'b0;
    end else begin
      wdt_clear   <= halt_take | clr_take;
      pc_sp_reset <= wake_done & wake_wdt;
      irq_take    <= wake_done & ~wake_wdt & wake_irq &
                     irq_serviceable;
      resume_next <= wake_done & ~wake_wdt &
                     ~(wake_irq & irq_serviceable);
    end
  end
  // ----------------------------------------------------------------------
  // clock gating by mode
  // ----------------------------------------------------------------------
  // the fast source restarts as soon as a wake begins, since the wake
  // count from sleep or idle_clock_stopped is timed in its own ticks
  always @* begin
    mode_stops_fast = ((power_mode == `OMW_MODE_SLEEP) |
                       (power_mode == `OMW_MODE_IDLE_CLOCK_STOPPED)) &
                      ~waking;
  end
  // outputs are registered so downstream gating sees clean levels
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      high_speed_clock_en <= 1'b1;
      sysclk_tick         <= 1'b0;
      sysclk_is_sub       <= 1'b0;
      sub_clock_en        <= 1'b1;
      time_base_en        <= 1'b1;
      cpu_halted          <= 1'b0;
      hold_state          <= 1'b0;
    end else begin
      high_speed_clock_en <= fast_on;
      sysclk_is_sub       <= sel_sub;
      // the core sees no ticks while its clock is stopped
      sysclk_tick         <= ~mode_stops_fast &
                             (sel_sub ? slow_osc_tick : div_hit);
      sub_clock_en        <= 1'b1;
      time_base_en        <= (power_mode != `OMW_MODE_SLEEP);
      cpu_halted          <= in_pd;
      // tells memory, registers and ports to hold their contents
      hold_state          <= in_pd;
    end
  end
  // ----------------------------------------------------------------------
  // oscillator ready flags
  // ----------------------------------------------------------------------
  // fast ready is held low while its source is stopped or deselected;
  // the slow source never stops, so its flag dips only on a wake
  omw_settle_cnt u_fast_rdy (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .hold    (mode_stops_fast | ~sel_fast),
    .start   (1'b0),
    .load    (`OMW_FAST_SETTLE),
    .tick    (fast_osc_tick),
    .ready   (fast_osc_ready_flag)
  );
  omw_settle_cnt u_slow_rdy (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .hold    (1'b0),
    .start   (wake_evt),
    .load    (`OMW_SLOW_SETTLE),
    .tick    (slow_osc_tick),
    .ready   (slow_osc_ready_flag)
  );
endmodule // omw_mode_ctrl

//--- omw_regs.vh
// constants for the operating mode and wake-up controller
`ifndef OMW_REGS_VH
`define OMW_REGS_VH
// ----------------------------------------------------------------------
// divider select codes
// ----------------------------------------------------------------------
`define OMW_DIV_SUB0     3'h0
`define OMW_DIV_SUB1     3'h1
`define OMW_DIV_64       3'h2
`define OMW_DIV_32       3'h3
`define OMW_DIV_16       3'h4
`define OMW_DIV_8        3'h5
`define OMW_DIV_4        3'h6
`define OMW_DIV_2        3'h7
// ----------------------------------------------------------------------
// reset values of mode bits
// ----------------------------------------------------------------------
`define OMW_RST_HIGH_CLOCK_SELECT    1'h1
`define OMW_RST_IDLE_ON_POWERDOWN_ENABLE    1'h1
`define OMW_RST_DIVSEL   3'h0
`define OMW_RST_KEEP     1'h0
// ----------------------------------------------------------------------
// power modes
// ----------------------------------------------------------------------
`define OMW_MODE_RUN     2'h0
`define OMW_MODE_SLEEP   2'h1
`define OMW_MODE_IDLE_CLOCK_STOPPED   2'h2
`define OMW_MODE_IDLE_CLOCK_RUNNING   2'h3
// ----------------------------------------------------------------------
// timing counts, in cycles of the oscillator concerned, and signal widths
// ----------------------------------------------------------------------
`define OMW_FAST_SETTLE  5'h0F
`define OMW_SHORT_SETTLE 5'h01
`define OMW_SLOW_SETTLE  5'h01
`define OMW_CNT_W        5
`define OMW_PORTA_W      8
`define OMW_IRQ_W        8
`endif

//--- omw_edge_det.v
// falling-edge detector with enable for one wake pin
`timescale 1ns/10ps
module omw_edge_det (
  // clock and reset
  input  wire clk_sys,
  input  wire arst_n,
  // pin
  input  wire pin,
  input  wire enable,
  // result
  output reg  fall
);
  reg pin_q;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_q <= 1'b1;
      fall  <= 1'b0;
    end else begin
      pin_q <= pin;
      fall  <= enable & pin_q & ~pin;
    end
  end
endmodule // omw_edge_det

//--- omw_settle_cnt.v
// settle counter: ready rises load plus one oscillator ticks after hold or start; after reset the count starts from OMW_FAST_SETTLE
`timescale 1ns/10ps
`include "omw_regs.vh"
module omw_settle_cnt (
  // clock and reset
  input  wire                 clk_sys,
  input  wire                 arst_n,
  // control
  input  wire                 hold,
  input  wire                 start,
  input  wire [`OMW_CNT_W-1:0] load,
  input  wire                 tick,
  // status
  output reg                  ready
);
  reg [`OMW_CNT_W-1:0] count;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count <= `OMW_FAST_SETTLE;
      ready <= 1'b0;
    end else if (hold) begin
      ready <= 1'b0;
      count <= load;
    end else if (start) begin
      ready <= 1'b0;
      count <= load;
    end else if (!ready && tick) begin
      if (count == {`OMW_CNT_W{1'b0}})
        ready <= 1'b1;
      else
        count <= count - 1'b1;
    end
  end
endmodule // omw_settle_cnt

//--- omw_mode_props.sv
// assertions for the operating mode and wake-up controller
`timescale 1ns/10ps
module omw_mode_props (
  // clock and reset
  input wire       clk_sys,
  input wire       arst_n,
  // mode inputs
  input wire       high_clock_select,
  input wire [2:0] sysclk_divider_select,
  input wire       idle_on_powerdown_enable,
  input wire       keep_sysclk_in_idle,
  input wire       halt_exec,
  input wire       clr_wdt_exec,
  input wire       wdt_overflow,
  // watched outputs
  input wire       high_speed_clock_en,
  input wire       sysclk_is_sub,
  input wire       sub_clock_en,
  input wire       time_base_en,
  input wire       cpu_halted,
  input wire       wdt_clear,
  input wire       pc_sp_reset,
  input wire [1:0] power_mode,
  input wire       power_down_flag,
  input wire       wdt_expiry_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire run = (power_mode == 2'h0);
  halt_flags_a:
    assert property (halt_exec && run |=> power_down_flag && !wdt_expiry_flag
                     && wdt_clear) else $error("halt flags wrong");
  sleep_pick_a:
    assert property (halt_exec && run && !idle_on_powerdown_enable
                     |=> power_mode == 2'h1) else $error("sleep not entered");
  idle_pick_a:
    assert property (halt_exec && run && idle_on_powerdown_enable
                     |=> power_mode == {1'b1, $past(keep_sysclk_in_idle)})
    else $error("idle mode wrong");
  cpu_stop_a:
    assert property (halt_exec && run |=> ##1 cpu_halted)
    else $error("cpu not halted");
  sleep_tb_a:
    assert property (power_mode == 2'h1 && $past(power_mode) == 2'h1
                     |-> !time_base_en) else $error("time base runs");
  sub_on_a:
    assert property (sub_clock_en) else $error("sub clock stopped");
  wdt_wake_a:
    assert property (wdt_overflow && !run |=> wdt_expiry_flag)
    else $error("timeout flag not set");
  clr_pdf_a:
    assert property (clr_wdt_exec && !halt_exec && run |=> !power_down_flag)
    else $error("power down flag kept");
  slow_sel_a:
    assert property ((!high_clock_select && sysclk_divider_select < 3'h2)[*8]
                     |-> sysclk_is_sub && !high_speed_clock_en)
    else $error("slow mode not taken");
  fast_on_a:
    assert property (((high_clock_select || sysclk_divider_select > 3'h1)
                      && run)[*3] |-> high_speed_clock_en)
    else $error("fast source off");
  pc_reset_a:
    assert property (pc_sp_reset |-> wdt_expiry_flag)
    else $error("pc reset without timeout");
endmodule // omw_mode_props
bind omw_mode_ctrl omw_mode_props omw_mode_props_inst (.*);

//--- omw_far_model.sv
// oscillator and watchdog model on the far side of the mode controller
`timescale 1ns/10ps
module omw_far_model #(parameter SLOW_DIV = 4) (
  // clock and reset
  input  wire clk_sys,
  input  wire arst_n,
  // controls
  input  wire high_speed_clock_en,
  input  wire wdt_fire,
  // outputs
  output reg  fast_osc_tick,
  output reg  slow_osc_tick,
  output reg  wdt_overflow
);
  integer div;
  reg     fire_d;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fast_osc_tick <= 1'b0;
      slow_osc_tick <= 1'b0;
      wdt_overflow  <= 1'b0;
      fire_d        <= 1'b0;
      div           <= 0;
    end else begin
      // a stopped fast source gives no ticks at all
      fast_osc_tick <= high_speed_clock_en;
      div           <= (div == SLOW_DIV - 1) ? 0 : div + 1;
      slow_osc_tick <= (div == 0);
      fire_d        <= wdt_fire;
      wdt_overflow  <= wdt_fire & ~fire_d;
    end
  end
endmodule // omw_far_model

//--- operating_mode_and_wakeup_control_tb_top.sv
// self-checking testbench for the mode and wake-up controller
`timescale 1ns/10ps
`include "omw_regs.vh"
module operating_mode_and_wakeup_control_tb_top;
  reg        clk_sys, arst_n, wdt_fire, high_clock_select, stack_full;
  reg        idle_on_powerdown_enable, keep_sysclk_in_idle, halt_exec;
  reg        clr_wdt_exec, global_irq_enable, s_pc, s_take, s_res;
  reg  [2:0] sysclk_divider_select;
  reg  [7:0] irq_req, irq_enable, port_a_in, port_a_wake_mask;
  wire       fast_osc_tick, slow_osc_tick, wdt_overflow, high_speed_clock_en;
  wire       sysclk_tick, sysclk_is_sub, sub_clock_en, time_base_en;
  wire       cpu_halted, hold_state, wdt_clear, pc_sp_reset, irq_take;
  wire       resume_next, power_down_flag, wdt_expiry_flag;
  wire       fast_osc_ready_flag, slow_osc_ready_flag;
  wire [1:0] power_mode;
  integer    error_cnt, n_tests, cyc, k, n;
  omw_mode_ctrl omw_mode_ctrl_inst (.*);
  omw_far_model omw_far_model_inst (.*);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // --------
  // tasks
  // --------
  task chk(input string nm, input [8:0] exp, input [8:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task step;
    begin
      @(negedge clk_sys);
      s_pc = s_pc | pc_sp_reset;
      s_take = s_take | irq_take;
      s_res = s_res | resume_next;
    end
  endtask
  task bound(input integer lim);
    if (cyc >= lim) begin
      $display("unexpected wait: expected at most %0d cycles, seen %0d",
               lim, cyc);
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  endtask
  task wait_run(input integer lim);
    begin
      cyc = 0;
      s_pc = 1'b0;
      s_take = 1'b0;
      s_res = 1'b0;
      while (power_mode !== `OMW_MODE_RUN && cyc < lim) begin
        step;
        cyc = cyc + 1;
      end
      repeat (2) step;
      bound(lim);
    end
  endtask
  task wait_rdy(input slow);
    begin
      cyc = 0;
      while ((slow ? slow_osc_ready_flag : fast_osc_ready_flag) !== 1'b1
             && cyc < 200) begin
        step;
        cyc = cyc + 1;
      end
      bound(200);
    end
  endtask
  task do_halt(input ie, input kp, input [1:0] md);
    begin
      idle_on_powerdown_enable = ie;
      keep_sysclk_in_idle = kp;
      halt_exec = 1'b1;
      @(negedge clk_sys);
      halt_exec = 1'b0;
      chk("power_down_flag", 1, power_down_flag);
      chk("wdt_expiry_flag", 0, wdt_expiry_flag);
      chk("wdt_clear", 1, wdt_clear);
      idle_on_powerdown_enable = ~ie;
      keep_sysclk_in_idle = ~kp;
      step;
      chk("cpu_halted", 1, cpu_halted);
      chk("hold_state", 1, hold_state);
      chk("power_mode", md, power_mode);
    end
  endtask
  task fire(input integer lim);
    begin
      wdt_fire = 1'b1;
      wait_run(lim);
      wdt_fire = 1'b0;
      chk("pc_sp_reset", 1, s_pc);
    end
  endtask
  // --------
  // scenarios
  // --------
  initial begin
    arst_n = 1'b0;
    wdt_fire = 1'b0;
    high_clock_select = 1'b1;
    sysclk_divider_select = 3'h0;
    stack_full = 1'b0;
    idle_on_powerdown_enable = 1'b1;
    keep_sysclk_in_idle = 1'b0;
    halt_exec = 1'b0;
    clr_wdt_exec = 1'b0;
    global_irq_enable = 1'b1;
    irq_req = 8'h00;
    irq_enable = 8'hFF;
    port_a_in = 8'hFF;
    port_a_wake_mask = 8'h04;
    error_cnt = 0;
    n_tests = 0;
    repeat (4) @(negedge clk_sys);
    arst_n = 1'b1;
    step;
    chk("power_down_flag", 0, power_down_flag);
    wait_rdy(1'b1);
    wait_rdy(1'b0);
    do_halt(1'b0, 1'b0, `OMW_MODE_SLEEP);
    chk("fast_osc_ready_flag", 0, fast_osc_ready_flag);
    fire(40);
    chk("sleep wake time", 1, cyc >= 15 && cyc <= 20);
    chk("wdt_expiry_flag", 1, wdt_expiry_flag);
    wait_rdy(1'b0);
    clr_wdt_exec = 1'b1;
    step;
    clr_wdt_exec = 1'b0;
    chk("power_down_flag", 0, power_down_flag);
    do_halt(1'b1, 1'b0, `OMW_MODE_IDLE_CLOCK_STOPPED);
    chk("time_base_en", 1, time_base_en);
    port_a_in = 8'hFE;
    repeat (20) step;
    chk("power_mode", `OMW_MODE_IDLE_CLOCK_STOPPED, power_mode);
    port_a_in = 8'hFA;
    wait_run(40);
    chk("resume_next", 1, s_res);
    chk("idle_clock_stopped wake time", 1, cyc >= 15 && cyc <= 20);
    port_a_in = 8'hFF;
    do_halt(1'b1, 1'b1, `OMW_MODE_IDLE_CLOCK_RUNNING);
    irq_req = 8'h01;
    wait_run(10);
    chk("irq_take", 1, s_take);
    chk("idle_clock_running wake time", 1, cyc <= 5);
    irq_req = 8'h00;
    stack_full = 1'b1;
    do_halt(1'b1, 1'b1, `OMW_MODE_IDLE_CLOCK_RUNNING);
    irq_req = 8'h02;
    wait_run(10);
    chk("resume without service", 1, {s_take, s_res});
    irq_req = 8'h04;
    stack_full = 1'b0;
    do_halt(1'b0, 1'b0, `OMW_MODE_SLEEP);
    repeat (30) step;
    chk("power_mode", `OMW_MODE_SLEEP, power_mode);
    fire(40);
    irq_req = 8'h00;
    for (k = 2; k < 9; k = k + 1) begin
      sysclk_divider_select = k[2:0];
      high_clock_select = (k == 8);
      repeat (4) step;
      n = 0;
      repeat (256) begin
        step;
        n = n + sysclk_tick;
      end
      cyc = 4 << (k - 2);
      chk("sysclk_tick count", 1, n >= cyc - 1 && n <= cyc + 1);
    end
    high_clock_select = 1'b0;
    sysclk_divider_select = 3'h1;
    wait_rdy(1'b1);
    repeat (10) step;
    chk("sysclk_is_sub", 1, sysclk_is_sub);
    chk("high_speed_clock_en", 0, high_speed_clock_en);
    do_halt(1'b0, 1'b0, `OMW_MODE_SLEEP);
    fire(60);
    chk("slow wake time", 1, cyc >= 3 && cyc <= 14);
    sysclk_divider_select = 3'h7;
    step;
    wait_rdy(1'b0);
    chk("sysclk_is_sub", 0, sysclk_is_sub);
    wrap_up;
  end
endmodule // operating_mode_and_wakeup_control_tb_top
